/* include/nav_setup_pkg.sv */
// Constants and carrier types for the navigation receiver setup command decoder.
// Assumes commands arrive already de-framed and de-stuffed, one byte per beat.
package nav_setup_pkg;

  // ----------------------------------------------------------------
  // Command and report codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_POS_XYZ = 8'h23;
  localparam logic [7:0] CMD_POS_LLA = 8'h2b;
  localparam logic [7:0] CMD_PARAMS = 8'h2c;
  localparam logic [7:0] CMD_OSC = 8'h2d;
  localparam logic [7:0] CMD_TIME = 8'h2e;
  localparam logic [7:0] CMD_UTC = 8'h2f;
  localparam logic [7:0] CMD_ACC_XYZ = 8'h31;
  localparam logic [7:0] RPT_BAD = 8'h13;
  localparam logic [7:0] RPT_PARAMS = 8'h4c;
  localparam logic [7:0] RPT_OSC = 8'h4d;
  localparam logic [7:0] RPT_TIME = 8'h4e;
  localparam logic [7:0] RPT_UTC = 8'h4f;
  localparam logic [7:0] CMD_NEWER_PARAMS = 8'hbb;

  // ----------------------------------------------------------------
  // Payload lengths and field offsets (bytes)
  // ----------------------------------------------------------------
  localparam logic [4:0] LEN_NONE = 5'h00;
  localparam logic [4:0] LEN_POS = 5'h0c;
  localparam logic [4:0] LEN_PARAMS = 5'h11;
  localparam logic [4:0] LEN_TIME = 5'h06;
  localparam logic [4:0] OFS_A = 5'h00;
  localparam logic [4:0] OFS_B = 5'h04;
  localparam logic [4:0] OFS_C = 5'h08;
  localparam logic [4:0] OFS_DYN = 5'h00;
  localparam logic [4:0] OFS_ELEV = 5'h01;
  localparam logic [4:0] OFS_SIG = 5'h05;
  localparam logic [4:0] OFS_DOP = 5'h09;
  localparam logic [4:0] OFS_DSW = 5'h0d;
  localparam logic [4:0] OFS_TOW = 5'h00;
  localparam logic [4:0] OFS_WEEK = 5'h04;
  // Report lengths, code byte included
  localparam logic [4:0] RLEN_PARAMS = 5'h12;
  localparam logic [4:0] RLEN_OSC = 5'h05;
  localparam logic [4:0] RLEN_TIME = 5'h07;
  localparam logic [4:0] RLEN_UTC = 5'h03;
  localparam logic [4:0] RLEN_BAD_HDR = 5'h02;

  // ----------------------------------------------------------------
  // Parameter codes and defaults
  // ----------------------------------------------------------------
  localparam logic [7:0] DYN_KEEP = 8'h00;
  localparam logic [7:0] DYN_LAND = 8'h01;
  localparam logic [7:0] DYN_AIR = 8'h03;
  localparam logic [31:0] ELEV_DEF = 32'h3db2b8d4;
  localparam logic [31:0] SIG_DEF = 32'h40800000;
  localparam logic [31:0] DOP_DEF = 32'h41400000;
  localparam logic [31:0] DSW_DEF = 32'h40a00000;
  localparam logic [2:0] MODE_AUTO = 3'h0;
  localparam logic [2:0] MODE_2D = 3'h3;
  localparam logic [2:0] MODE_3D = 3'h4;
  localparam logic [3:0] MIN_SV_3D = 4'h4;
  localparam logic [3:0] MIN_SV_2D = 4'h3;
  // Week count epoch: week 0 starts 6 Jan 1980, seconds from Sunday 00:00
  localparam int EPOCH_YEAR = 1980;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_DYN = 12'h008;
  localparam logic [11:0] REG_ELEV = 12'h00c;
  localparam logic [11:0] REG_SIG = 12'h010;
  localparam logic [11:0] REG_DOP = 12'h014;
  localparam logic [11:0] REG_DSW = 12'h018;
  localparam logic [11:0] REG_TOW = 12'h01c;
  localparam logic [11:0] REG_WEEK = 12'h020;
  localparam logic [11:0] REG_POS_A = 12'h024;
  localparam logic [11:0] REG_POS_B = 12'h028;
  localparam logic [11:0] REG_POS_C = 12'h02c;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {DIM_NONE, DIM_2D, DIM_3D} fix_dim_e;
  typedef struct packed {
    logic first;
    logic last;
    logic [7:0] data;
  } pkt_byte_s;

endpackage

/* verilog/nav_setup_cmds.sv */
// Setup command decoder: parses commands 0x23..0x31, keeps the setup state and answers.
// Assumes a framing layer on the same clock delivers bytes with first/last marks.
//
// How it works
// - Lat/lon/alt position holds three MSB-first singles: lat, lon, alt.
// - Approximate position is dropped unchanged while fixes are being produced.
// - Parameter command always answers with report 0x4C holding current values.
// - Dynamics code 0 keeps setting; 1 land default, 2 sea, 3 air.
// - Elevation mask default five degrees; satellites below it are unusable.
// - Signal mask default 4; weaker satellites are unusable for fixes.
// - DOP mask default 12; no fix while DOP exceeds it.
// - PDOP switch default 5 picks 3D or 2D in auto mode.
// - Auto: 3D with four satellites and PDOP within switch, else 2D.
// - PDOP switch only matters in auto mode, ignored in fixed modes.
// - Negative single field keeps its setting; rstn reloads the default settings.
// - Old parameter command stays accepted though 0xBB replaces it.
// - Oscillator request has no data and answers report 0x4D.
// - Set time: single time of week, INT16 week, answered by 0x4E.
// - Week 0 begins 6 Jan 1980; seconds count from Sunday midnight.
// - Set time is dropped once time came from a tracked satellite.
// - UTC request has no data and answers 0x4F with leap seconds.
// - Accurate XYZ position carries X, Y, Z singles in meters.
// - Accurate position is taken as exact and drives acquisition aiding.
// - Unparseable command is echoed with 0x13 before its code.
`timescale 1ns/1ps
`default_nettype none

module nav_setup_cmds
  import nav_setup_pkg::*;
#(
  parameter int BUF_BYTES = 17
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // APB register port
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Command bytes from the framing layer
  input wire logic in_valid,
  input wire pkt_byte_s in_byte,
  output logic in_ready,
  // Report bytes to the framing layer
  output logic out_valid,
  output pkt_byte_s out_byte,
  input wire logic out_ready,
  // Tracking state
  input wire logic time_from_sv,
  input wire logic [3:0] sv_count,
  input wire logic [31:0] pdop,
  input wire logic [31:0] hdop,
  input wire logic [31:0] sv_elev,
  input wire logic [31:0] sv_level,
  input wire logic [31:0] osc_offset,
  input wire logic [15:0] leap_seconds,
  // Setup results
  output logic [7:0] dynamics,
  output logic pos_load,
  output logic pos_accurate,
  output fix_dim_e fix_dim,
  output logic sv_usable
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Float compare a > b; sign-magnitude ordering, +0 equals -0
  function automatic logic f_gt(input logic [31:0] a, input logic [31:0] b);
    if (a[31] != b[31]) return b[31] && !(a[30:0] == 31'h0 && b[30:0] == 31'h0);
    else if (a[31]) return a[30:0] < b[30:0];
    else return a[30:0] > b[30:0];
  endfunction

  // Byte j of a 136-bit MSB-first field vector
  function automatic logic [7:0] pick(input logic [135:0] v, input logic [4:0] j);
    return v[135 - 8 * int'(j) -: 8];
  endfunction

  typedef enum logic [1:0] {ST_RX, ST_EXEC, ST_SEND} state_e;

  state_e state;
  logic [7:0] buf_mem [BUF_BYTES];
  logic [7:0] cmd;
  logic [4:0] cnt;
  logic ovf;
  logic [31:0] elev_mask, sig_mask, dop_mask, dop_switch;
  logic [31:0] tow;
  logic [15:0] week;
  logic time_set;
  logic [31:0] pos_a, pos_b, pos_c;
  logic pos_valid, pos_llh;
  logic [2:0] fix_mode;
  logic [7:0] rsp_code;
  logic [4:0] rsp_len, idx;
  logic [7:0] out_data;

  // Single at a payload offset, MSB first
  function automatic logic [31:0] be32(input logic [4:0] o);
    return {buf_mem[o], buf_mem[o + 5'h1], buf_mem[o + 5'h2], buf_mem[o + 5'h3]};
  endfunction

  // ----------------------------------------------------------------
  // Command reception
  // ----------------------------------------------------------------
  assign in_ready = (state == ST_RX);

  logic take;
  assign take = in_valid && in_ready;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd <= 8'h00;
      cnt <= 5'h00;
      ovf <= 1'b0;
    end else if (take) begin
      if (in_byte.first) begin
        cmd <= in_byte.data;
        cnt <= 5'h00;
        ovf <= 1'b0;
      end else if (int'(cnt) < BUF_BYTES) begin
        cnt <= cnt + 5'h1;
      end else begin
        ovf <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (take && !in_byte.first && int'(cnt) < BUF_BYTES) begin
      buf_mem[cnt] <= in_byte.data;
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic len_ok, fixing, is_exec;
  logic [7:0] exec_code;
  logic [4:0] exec_len;

  assign fixing = (fix_dim != DIM_NONE);
  assign is_exec = (state == ST_EXEC);

  always_comb begin
    case (cmd)
      CMD_POS_XYZ, CMD_POS_LLA, CMD_ACC_XYZ: len_ok = (cnt == LEN_POS);
      CMD_PARAMS: len_ok = (cnt == LEN_PARAMS);
      CMD_TIME: len_ok = (cnt == LEN_TIME);
      CMD_OSC, CMD_UTC: len_ok = (cnt == LEN_NONE);
      default: len_ok = 1'b0;
    endcase
    if (ovf) len_ok = 1'b0;
  end

  always_comb begin
    exec_code = 8'h00;
    exec_len = 5'h00;
    if (!len_ok) begin
      exec_code = RPT_BAD;
      exec_len = cnt + RLEN_BAD_HDR;
    end else begin
      case (cmd)
        CMD_PARAMS: begin
          exec_code = RPT_PARAMS;
          exec_len = RLEN_PARAMS;
        end
        CMD_OSC: begin
          exec_code = RPT_OSC;
          exec_len = RLEN_OSC;
        end
        CMD_TIME: begin
          exec_code = time_from_sv ? 8'h00 : RPT_TIME;
          exec_len = time_from_sv ? 5'h00 : RLEN_TIME;
        end
        CMD_UTC: begin
          exec_code = RPT_UTC;
          exec_len = RLEN_UTC;
        end
        default: begin
          exec_code = 8'h00;
          exec_len = 5'h00;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_RX;
      idx <= 5'h00;
      rsp_code <= 8'h00;
      rsp_len <= 5'h00;
    end else begin
      case (state)
        ST_RX: if (take && in_byte.last) state <= ST_EXEC;
        ST_EXEC: begin
          idx <= 5'h00;
          rsp_code <= exec_code;
          rsp_len <= exec_len;
          state <= (exec_len == 5'h00) ? ST_RX : ST_SEND;
        end
        ST_SEND: if (out_ready) begin
          if (idx == rsp_len - 5'h1) state <= ST_RX;
          else idx <= idx + 5'h1;
        end
        default: state <= ST_RX;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Parameters
  // ----------------------------------------------------------------
  logic do_params;
  assign do_params = is_exec && len_ok && cmd == CMD_PARAMS;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dynamics <= DYN_LAND;
      elev_mask <= ELEV_DEF;
      sig_mask <= SIG_DEF;
      dop_mask <= DOP_DEF;
      dop_switch <= DSW_DEF;
    end else if (do_params) begin
      if (buf_mem[OFS_DYN] != DYN_KEEP && buf_mem[OFS_DYN] <= DYN_AIR)
        dynamics <= buf_mem[OFS_DYN];
      if (!buf_mem[OFS_ELEV][7]) elev_mask <= be32(OFS_ELEV);
      if (!buf_mem[OFS_SIG][7]) sig_mask <= be32(OFS_SIG);
      if (!buf_mem[OFS_DOP][7]) dop_mask <= be32(OFS_DOP);
      if (!buf_mem[OFS_DSW][7]) dop_switch <= be32(OFS_DSW);
    end
  end

  // ----------------------------------------------------------------
  // Position and time
  // ----------------------------------------------------------------
  logic do_pos, do_time;
  assign do_pos = is_exec && len_ok && (cmd == CMD_ACC_XYZ ||
                  ((cmd == CMD_POS_XYZ || cmd == CMD_POS_LLA) && !fixing));
  assign do_time = is_exec && len_ok && cmd == CMD_TIME && !time_from_sv;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pos_a <= 32'h0;
      pos_b <= 32'h0;
      pos_c <= 32'h0;
      pos_valid <= 1'b0;
      pos_llh <= 1'b0;
      pos_accurate <= 1'b0;
      pos_load <= 1'b0;
    end else begin
      pos_load <= do_pos;
      if (do_pos) begin
        pos_a <= be32(OFS_A);
        pos_b <= be32(OFS_B);
        pos_c <= be32(OFS_C);
        pos_valid <= 1'b1;
        pos_llh <= (cmd == CMD_POS_LLA);
        pos_accurate <= (cmd == CMD_ACC_XYZ);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tow <= 32'h0;
      week <= 16'h0;
      time_set <= 1'b0;
    end else if (do_time) begin
      tow <= be32(OFS_TOW);
      week <= {buf_mem[OFS_WEEK], buf_mem[OFS_WEEK + 5'h1]};
      time_set <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Fix dimension and satellite use
  // ----------------------------------------------------------------
  fix_dim_e next_fix_dim;
  logic ok3d, ok2d;

  assign ok3d = sv_count >= MIN_SV_3D && !f_gt(pdop, dop_mask);
  assign ok2d = sv_count >= MIN_SV_2D && !f_gt(hdop, dop_mask);

  always_comb begin
    case (fix_mode)
      MODE_AUTO: begin
        if (ok3d && !f_gt(pdop, dop_switch)) next_fix_dim = DIM_3D;
        else if (ok2d) next_fix_dim = DIM_2D;
        else next_fix_dim = DIM_NONE;
      end
      MODE_2D: next_fix_dim = ok2d ? DIM_2D : DIM_NONE;
      MODE_3D: next_fix_dim = ok3d ? DIM_3D : DIM_NONE;
      default: next_fix_dim = DIM_NONE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fix_dim <= DIM_NONE;
      sv_usable <= 1'b0;
    end else begin
      fix_dim <= next_fix_dim;
      sv_usable <= !f_gt(elev_mask, sv_elev) && !f_gt(sig_mask, sv_level);
    end
  end

  // ----------------------------------------------------------------
  // Report output
  // ----------------------------------------------------------------
  logic [4:0] sel_idx;
  logic [7:0] sel_code, sel_byte;
  logic [135:0] vec;

  assign sel_idx = is_exec ? 5'h00 : idx + 5'h1;
  assign sel_code = is_exec ? exec_code : rsp_code;

  always_comb begin
    case (sel_code)
      RPT_PARAMS: vec = {dynamics, elev_mask, sig_mask, dop_mask, dop_switch};
      RPT_OSC: vec = {osc_offset, 104'h0};
      RPT_TIME: vec = {tow, week, 88'h0};
      RPT_UTC: vec = {leap_seconds, 120'h0};
      default: vec = 136'h0;
    endcase
    if (sel_idx == 5'h00) sel_byte = sel_code;
    else if (sel_code == RPT_BAD && sel_idx == 5'h01) sel_byte = cmd;
    else if (sel_code == RPT_BAD) sel_byte = buf_mem[sel_idx - RLEN_BAD_HDR];
    else sel_byte = pick(vec, sel_idx - 5'h1);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) out_data <= 8'h00;
    else if (is_exec || (state == ST_SEND && out_ready)) out_data <= sel_byte;
  end

  assign out_valid = (state == ST_SEND);
  assign out_byte = '{first: idx == 5'h00, last: idx == rsp_len - 5'h1, data: out_data};

  // ----------------------------------------------------------------
  // APB registers
  // ----------------------------------------------------------------
  logic mapped;
  assign pready = 1'b1;

  always_comb begin
    mapped = 1'b1;
    case (paddr)
      REG_CTRL: prdata = {29'h0, fix_mode};
      REG_STATUS: prdata = {25'h0, pos_llh, pos_accurate, pos_valid, time_set,
                            time_from_sv, fix_dim};
      REG_DYN: prdata = {24'h0, dynamics};
      REG_ELEV: prdata = elev_mask;
      REG_SIG: prdata = sig_mask;
      REG_DOP: prdata = dop_mask;
      REG_DSW: prdata = dop_switch;
      REG_TOW: prdata = tow;
      REG_WEEK: prdata = {16'h0, week};
      REG_POS_A: prdata = pos_a;
      REG_POS_B: prdata = pos_b;
      REG_POS_C: prdata = pos_c;
      default: begin
        prdata = 32'h0;
        mapped = 1'b0;
      end
    endcase
  end

  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) fix_mode <= MODE_AUTO;
    else if (psel && penable && pwrite && paddr == REG_CTRL) fix_mode <= pwdata[2:0];
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_params_report: assert property (@(posedge clk) disable iff (!rstn)
    do_params |=> out_valid && out_data == RPT_PARAMS && rsp_len == RLEN_PARAMS)
    else $error("parameter command not answered with 0x4C");

  chk_approx_drop: assert property (@(posedge clk) disable iff (!rstn)
    is_exec && cmd == CMD_POS_XYZ && fixing |=> !pos_load && $stable(pos_a))
    else $error("approximate position taken while fixing");

  chk_negative_keep: assert property (@(posedge clk) disable iff (!rstn)
    do_params && buf_mem[OFS_ELEV][7] |=> $stable(elev_mask))
    else $error("negative elevation field changed the mask");

  chk_dyn_keep: assert property (@(posedge clk) disable iff (!rstn)
    do_params && buf_mem[OFS_DYN] == DYN_KEEP |=> dynamics == $past(dynamics))
    else $error("dynamics code 0 changed the setting");

  chk_auto_3d: assert property (@(posedge clk) disable iff (!rstn)
    fix_mode == MODE_AUTO && sv_count >= MIN_SV_3D && !f_gt(pdop, dop_switch)
    && !f_gt(pdop, dop_mask) |=> fix_dim == DIM_3D)
    else $error("auto mode missed a 3D fix");

  chk_mask_nofix: assert property (@(posedge clk) disable iff (!rstn)
    fix_mode == MODE_3D && f_gt(pdop, dop_mask) |=> fix_dim == DIM_NONE)
    else $error("fix computed above DOP mask");

  chk_fixed_3d: assert property (@(posedge clk) disable iff (!rstn)
    fix_mode == MODE_3D && ok3d && f_gt(pdop, dop_switch) |=> fix_dim == DIM_3D)
    else $error("PDOP switch acted outside auto mode");

  chk_time_drop: assert property (@(posedge clk) disable iff (!rstn)
    is_exec && len_ok && cmd == CMD_TIME && time_from_sv |=> $stable(tow) && state == ST_RX)
    else $error("set time accepted after satellite time");

  chk_bad_echo: assert property (@(posedge clk) disable iff (!rstn)
    is_exec && !len_ok |=> out_data == RPT_BAD ##1 (out_valid && out_data == $past(cmd, 2))
    or (!out_ready && out_data == RPT_BAD))
    else $error("unparseable command not echoed with 0x13");

  chk_osc_report: assert property (@(posedge clk) disable iff (!rstn)
    is_exec && len_ok && cmd == CMD_OSC |=> out_valid && out_data == RPT_OSC)
    else $error("oscillator request not answered with 0x4D");

  chk_utc_report: assert property (@(posedge clk) disable iff (!rstn)
    is_exec && len_ok && cmd == CMD_UTC |=> out_data == RPT_UTC && rsp_len == RLEN_UTC)
    else $error("UTC request not answered with 0x4F");

  chk_accurate_pos: assert property (@(posedge clk) disable iff (!rstn)
    is_exec && len_ok && cmd == CMD_ACC_XYZ |=> pos_load && pos_accurate)
    else $error("accurate position not taken as exact");

  cov_params: cover property (@(posedge clk) disable iff (!rstn) do_params);
  cov_time_set: cover property (@(posedge clk) disable iff (!rstn) do_time);
  cov_bad: cover property (@(posedge clk) disable iff (!rstn) is_exec && !len_ok);
  cov_auto_2d: cover property (@(posedge clk) disable iff (!rstn)
    fix_mode == MODE_AUTO && fix_dim == DIM_2D);

endmodule

`default_nettype wire

/* verif/nav_host.sv */
// Host model: sends command packets and collects report bytes.
// Assumes the decoder's byte handshakes, all on clk.
`timescale 1ns/1ps
`default_nettype none
module nav_host
  import nav_setup_pkg::*;
(
  // Clock
  input wire logic clk,
  // Commands out
  output logic in_valid,
  output pkt_byte_s in_byte,
  input wire logic in_ready,
  // Reports in
  input wire logic out_valid,
  input wire pkt_byte_s out_byte,
  output logic out_ready
);
  logic [7:0] rx[$];
  logic [1:0] mk[$];
  logic stall = 1'b0;
  initial begin
    in_valid = 1'b0;
    in_byte = '0;
  end
  task automatic send(input logic [143:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      in_valid <= 1'b1;
      in_byte <= '{i == 0, i == n - 1, v[8*(n-1-i) +: 8]};
      @(posedge clk iff in_ready);
    end
    in_valid <= 1'b0;
    in_byte.data <= ~v[7:0];
  endtask
  // Slow mode stalls every other cycle
  always @(posedge clk) begin
    if (out_valid && out_ready) begin
      rx.push_back(out_byte.data);
      mk.push_back({out_byte.first, out_byte.last});
    end
    out_ready <= !stall || !out_ready;
  end
endmodule
`default_nettype wire

/* verif/nav_setup_cmds_tb.sv */
// Bench for the setup command decoder: APB, command stream, fix outputs.
// Assumes nav_host on the command side.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %h got %h", n, e, a); end end
module nav_setup_cmds_tb
  import nav_setup_pkg::*;
;
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, time_from_sv = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, pdop = 32'h0, hdop = 32'h0;
  logic [31:0] sv_elev = 32'h0, sv_level = 32'h0, osc_offset = 32'h12345678;
  logic [15:0] leap_seconds = 16'h0012;
  logic [3:0] sv_count = 4'h0;
  logic pready, pslverr, in_valid, in_ready, out_valid, out_ready, pos_load;
  logic pos_accurate, sv_usable, er;
  pkt_byte_s in_byte, out_byte;
  logic [7:0] dynamics;
  fix_dim_e fix_dim;
  int num_errors = 0, compares = 0, loads = 0;
  nav_setup_cmds u_nav_setup_cmds (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .in_valid, .in_byte, .in_ready, .out_valid, .out_byte,
    .out_ready, .time_from_sv, .sv_count, .pdop, .hdop, .sv_elev, .sv_level, .osc_offset,
    .leap_seconds, .dynamics, .pos_load, .pos_accurate, .fix_dim, .sv_usable);
  nav_host u_nav_host (.clk, .in_valid, .in_byte, .in_ready, .out_valid, .out_byte,
    .out_ready);
  initial forever #20 clk = ~clk;
  always @(posedge clk) if (pos_load) loads <= loads + 1;
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    // One idle edge so back-to-back calls never drive psel twice in a step
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk iff pready);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk_rpt(input logic [143:0] v, input int n);
    for (int k = 0; k < 90 && u_nav_host.rx.size() < n; k++) @(posedge clk);
    repeat (8) @(posedge clk);
    `CHK("report length", n, u_nav_host.rx.size())
    for (int i = 0; i < n && i < u_nav_host.rx.size(); i++) begin
      `CHK("report byte", v[8*(n-1-i) +: 8], u_nav_host.rx[i])
      `CHK("report marks", {i == 0, i == n - 1}, u_nav_host.mk[i])
    end
    u_nav_host.rx.delete();
    u_nav_host.mk.delete();
  endtask
  task automatic t_regs();
    logic [11:0] ra[5] = '{REG_DYN, REG_ELEV, REG_SIG, REG_DOP, REG_DSW};
    logic [31:0] ev[5] = '{32'h1, ELEV_DEF, SIG_DEF, DOP_DEF, DSW_DEF};
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ra[i], 32'h0);
      `CHK("default", ev[i], rd)
    end
    apb(1'b1, 12'h0fc, 32'h3);
    `CHK("unmapped", 1'b1, er)
  endtask
  task automatic t_set();
    u_nav_host.stall <= 1'b1;
    u_nav_host.send({8'h2c, 8'h03, 32'h3f800000, {3{32'hbf800000}}}, 18);
    chk_rpt({RPT_PARAMS, 8'h03, 32'h3f800000, SIG_DEF, DOP_DEF, DSW_DEF}, 18);
    `CHK("dynamics", 8'h03, dynamics)
    u_nav_host.stall <= 1'b0;
    u_nav_host.send({8'h2c, 8'h00, {4{32'hbf800000}}}, 18);
    chk_rpt({RPT_PARAMS, 8'h03, 32'h3f800000, SIG_DEF, DOP_DEF, DSW_DEF}, 18);
  endtask
  task automatic t_req();
    u_nav_host.send(144'h2d, 1);
    chk_rpt({RPT_OSC, osc_offset}, 5);
    u_nav_host.send(144'h2f, 1);
    chk_rpt({RPT_UTC, leap_seconds}, 3);
    u_nav_host.send(144'h55, 1);
    chk_rpt({RPT_BAD, 8'h55}, 2);
  endtask
  task automatic t_time();
    u_nav_host.send({8'h2e, 32'h41200000, 16'hfc01}, 7);
    chk_rpt({RPT_TIME, 32'h41200000, 16'hfc01}, 7);
    time_from_sv <= 1'b1;
    u_nav_host.send({8'h2e, 32'h42000000, 16'h0001}, 7);
    chk_rpt(144'h0, 0);
    apb(1'b0, REG_TOW, 32'h0);
    `CHK("time of week", 32'h41200000, rd)
    time_from_sv <= 1'b0;
  endtask
  task automatic t_pos();
    int l0;
    l0 = loads;
    u_nav_host.send({8'h2b, 32'h3f000000, 32'h40000000, 32'h42c80000}, 13);
    chk_rpt(144'h0, 0);
    `CHK("position load", l0 + 1, loads)
    apb(1'b0, REG_POS_B, 32'h0);
    `CHK("longitude", 32'h40000000, rd)
    u_nav_host.send({8'h31, 96'h1}, 13);
    chk_rpt(144'h0, 0);
    `CHK("accurate", 1'b1, pos_accurate)
    apb(1'b0, REG_POS_C, 32'h0);
    `CHK("accurate z", 32'h1, rd)
    sv_count <= 4'h4;
    pdop <= 32'h40000000;
    hdop <= 32'h40000000;
    l0 = loads;
    u_nav_host.send({8'h23, 96'h5}, 13);
    chk_rpt(144'h0, 0);
    `CHK("dropped load", l0, loads)
  endtask
  task automatic t_fix();
    `CHK("auto 3d", DIM_3D, fix_dim)
    pdop <= 32'h40c00000;
    repeat (3) @(posedge clk);
    `CHK("auto 2d", DIM_2D, fix_dim)
    apb(1'b1, REG_CTRL, {29'h0, MODE_3D});
    repeat (3) @(posedge clk);
    `CHK("fixed 3d", DIM_3D, fix_dim)
    sv_elev <= 32'h3f800000;
    sv_level <= 32'h40c00000;
    repeat (3) @(posedge clk);
    `CHK("usable", 1'b1, sv_usable)
    sv_level <= 32'h40000000;
    repeat (3) @(posedge clk);
    `CHK("weak", 1'b0, sv_usable)
  endtask
  task automatic report_and_stop();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_set();
    t_req();
    t_time();
    t_pos();
    t_fix();
    report_and_stop();
  end
endmodule
`default_nettype wire
